// ===== logic/temp_sensor_register_core.sv
// Purpose: register side of a three-channel thermometer on a serial bus
// Assumes: scl and sda arrive asynchronously, converter and limit logic
//          share ref_clk
// Notes:   sda is open drain: sdaOe high pulls the line low
`timescale 1ns/1ns

// Overview of operation
// RULE1 - default 0..127, extended -64..191 when selected
// RULE2 - new range valid from next measurement
// RULE3 - default range binary, clamped to 0..127
// RULE4 - extended range offset binary, plus 64
// RULE5 - format switches at next result, limits untouched
// RULE6 - host rewrites limits after switching range
// RULE7 - every register is eight bits
// RULE8 - first write byte loads the pointer
// RULE9 - later bytes write, reads use pointer
// RULE10 - pointer resets to zero, reads local
// RULE11 - results written by converter only, fixed addresses
// RULE12 - all five results reset to zero
// RULE13 - bank bit redirects remote one to two
// RULE14 - primary config read 0x03, written 0x09
// RULE15 - bit 7 suppresses alarm, not overtemp mode
// RULE16 - standby stops conversions, outputs inactive
// RULE17 - bit 5 selects alarm or second overtemp
// RULE18 - bits 1, 0 block remote alarms
// RULE19 - lock bit freezes lockable registers until reset
// RULE20 - low byte read freezes high until read
// RULE21 - low byte holds two fraction bits only
// RULE22 - writes to result registers are ignored
module temp_sensor_register_core #(
  parameter logic [6:0] SLAVE_ADDR = 7'h2a // arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sclIn,             // bus clock pin
  input  wire logic        sdaIn,             // bus data pin level
  output logic             sdaOut,            // level when driven
  output logic             sdaOe,             // pull data line low
  input  wire logic        resultValid,       // converter result pulse
  input  wire logic [1:0]  resultChannel,     // which channel
  input  wire logic [11:0] resultTemp,        // signed quarter degrees
  input  wire logic        localAlarmReq,     // local limit violated
  input  wire logic        remoteOneAlarmReq, // remote one violated
  input  wire logic        remoteTwoAlarmReq, // remote two violated
  input  wire logic        secondOvertempReq, // high limit comparator
  input  wire logic        overtempReq,       // overtemp comparator
  output logic             conversionEnable,  // converter may run
  output logic             extendedRange,     // range to the converter
  output logic             alarmPinOut,       // level when driven
  output logic             alarmPinOe,        // pull shared pin low
  output logic             overtempOut,       // level when driven
  output logic             overtempOe         // pull overtemp pin low
);

  // pin synchronisers and edge history
  logic [1:0]  sclSync;   // two-stage scl sync
  logic [1:0]  sdaSync;   // two-stage sda sync
  logic        sclPrev;   // scl one cycle back
  logic        sdaPrev;   // sda one cycle back
  logic        sclRise;   // scl rising edge
  logic        sclFall;   // scl falling edge
  logic        startCond; // start or repeated start
  logic        stopCond;  // stop

  // byte engine
  temp_core_pkg::bus_state_t busState;
  logic [2:0]  bitCnt;    // bit within byte
  logic        byteDone;  // eighth bit seen
  logic [7:0]  rxShift;   // received byte
  logic [7:0]  txShift;   // byte being sent
  logic        isRead;    // direction of transfer
  logic        firstData; // next written byte is the pointer
  logic        masterAck; // host acked last read byte
  logic        driveLow;  // sda pull-down

  // register file
  logic [7:0]  regPtr;    // register index pointer
  logic [7:0]  cfg1;      // primary config
  logic [7:0]  cfg2;      // secondary config
  logic [7:0]  resHigh [3]; // high bytes per channel
  logic [7:0]  resLow  [3]; // low bytes per channel
  logic [7:0]  readValue; // byte at the pointer
  logic        wrByte;    // a data byte completed
  logic        ptrWrite;  // pointer load strobe
  logic        regWrite;  // register write strobe
  logic        rdLoad;    // a byte is loaded for reading
  logic        locked;    // settings frozen
  logic        standby;   // conversions suspended
  logic        bankSel;   // remote two behind remote one
  logic        newResult; // accepted converter result
  logic [7:0]  fmtHigh;   // formatted high byte
  logic [7:0]  fmtLow;    // formatted low byte
  logic [2:0]  lowHit;    // low byte read per channel
  logic [2:0]  highHit;   // high byte read per channel
  logic [2:0]  frozen;    // high byte frozen per channel
  logic [2:0]  freezeArm; // low read, waiting for stop
  logic [2:0]  pendValid; // held result waiting
  logic [7:0]  pendHigh [3]; // held high bytes
  logic        pinAssert; // shared pin wants low

  assign locked   = cfg2[temp_core_pkg::LOCK_BIT];
  assign standby  = cfg1[temp_core_pkg::STANDBY_BIT];
  assign bankSel  = cfg1[temp_core_pkg::BANK_BIT];
  assign sdaOut   = 1'b0;
  assign sdaOe    = driveLow;
  assign alarmPinOut = 1'b0;
  assign overtempOut = 1'b0;

  // synchronise pins, first stage read only by second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
    end
  end

  // edge and bus condition detect
  assign sclRise   = sclSync[1] & ~sclPrev;
  assign sclFall   = ~sclSync[1] & sclPrev;
  assign startCond = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  assign stopCond  = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  // strobes out of the byte engine
  assign wrByte   = sclFall & byteDone &
                    (busState == temp_core_pkg::BUS_WDATA);
  assign ptrWrite = wrByte & firstData;  // [RULE8]
  assign regWrite = wrByte & ~firstData; // [RULE9]
  assign rdLoad   = sclFall &
                    (((busState == temp_core_pkg::BUS_ADDR_ACK) & isRead) |
                     ((busState == temp_core_pkg::BUS_MACK) & masterAck));

  // bus byte engine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busState  <= temp_core_pkg::BUS_IDLE;
      bitCnt    <= 3'h0;
      byteDone  <= 1'b0;
      rxShift   <= 8'h00;
      txShift   <= 8'h00;
      isRead    <= 1'b0;
      firstData <= 1'b1;
      masterAck <= 1'b0;
      driveLow  <= 1'b0;
    end else if (startCond) begin
      busState  <= temp_core_pkg::BUS_ADDR;
      bitCnt    <= 3'h0;
      byteDone  <= 1'b0;
      firstData <= 1'b1;
      driveLow  <= 1'b0;
    end else if (stopCond) begin
      busState  <= temp_core_pkg::BUS_IDLE;
      driveLow  <= 1'b0;
    end else if (sclRise) begin
      case (busState)
        temp_core_pkg::BUS_ADDR, temp_core_pkg::BUS_WDATA: begin
          rxShift  <= {rxShift[6:0], sdaSync[1]};
          bitCnt   <= bitCnt + 3'h1;
          byteDone <= (bitCnt == 3'h7);
        end
        temp_core_pkg::BUS_RDATA: begin
          bitCnt   <= bitCnt + 3'h1;
          byteDone <= (bitCnt == 3'h7);
        end
        temp_core_pkg::BUS_MACK: masterAck <= ~sdaSync[1];
        default: ;
      endcase
    end else if (sclFall) begin
      case (busState)
        temp_core_pkg::BUS_ADDR: begin
          if (byteDone) begin
            byteDone <= 1'b0;
            if (rxShift[7:1] == SLAVE_ADDR) begin
              isRead   <= rxShift[0];
              driveLow <= 1'b1;
              busState <= temp_core_pkg::BUS_ADDR_ACK;
            end else begin
              busState <= temp_core_pkg::BUS_IDLE; // not ours
            end
          end
        end
        temp_core_pkg::BUS_ADDR_ACK: begin
          if (isRead) begin
            txShift  <= readValue;
            driveLow <= ~readValue[7];
            busState <= temp_core_pkg::BUS_RDATA;
          end else begin
            driveLow <= 1'b0;
            busState <= temp_core_pkg::BUS_WDATA;
          end
        end
        temp_core_pkg::BUS_WDATA: begin
          if (byteDone) begin
            byteDone  <= 1'b0;
            firstData <= 1'b0;
            driveLow  <= 1'b1;
            busState  <= temp_core_pkg::BUS_WDATA_ACK;
          end
        end
        temp_core_pkg::BUS_WDATA_ACK: begin
          driveLow <= 1'b0;
          busState <= temp_core_pkg::BUS_WDATA;
        end
        temp_core_pkg::BUS_RDATA: begin
          if (byteDone) begin
            byteDone <= 1'b0;
            driveLow <= 1'b0;
            busState <= temp_core_pkg::BUS_MACK;
          end else begin
            txShift  <= {txShift[6:0], 1'b0};
            driveLow <= ~txShift[6];
          end
        end
        temp_core_pkg::BUS_MACK: begin
          if (masterAck) begin
            txShift  <= readValue; // same register again
            driveLow <= ~readValue[7];
            busState <= temp_core_pkg::BUS_RDATA;
          end else begin
            busState <= temp_core_pkg::BUS_IDLE;
          end
        end
        default: busState <= temp_core_pkg::BUS_IDLE;
      endcase
    end
  end

  // address pointer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regPtr <= temp_core_pkg::PTR_RESET; // [RULE10]
    end else if (ptrWrite) begin
      regPtr <= rxShift; // [RULE8]
    end
  end

  // configuration registers, frozen by the lock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg1 <= temp_core_pkg::CFG1_RESET;
      cfg2 <= temp_core_pkg::CFG2_RESET;
    end else if (regWrite && !locked) begin // [RULE19] [RULE22]
      if (regPtr == temp_core_pkg::ADDR_CFG1_WR) begin // [RULE14]
        cfg1 <= rxShift & temp_core_pkg::CFG1_WMASK;
      end
      if (regPtr == temp_core_pkg::ADDR_CFG2) begin
        cfg2 <= rxShift & temp_core_pkg::CFG2_WMASK;
      end
    end
  end

  // read multiplexer, all registers eight bits [RULE7]
  always_comb begin
    readValue = temp_core_pkg::READ_DEFAULT;
    lowHit    = 3'h0;
    highHit   = 3'h0;
    case (regPtr)
      temp_core_pkg::ADDR_LOCAL: readValue = resHigh[0]; // [RULE11]
      temp_core_pkg::ADDR_R1_HIGH: begin // [RULE13]
        readValue = bankSel ? resHigh[2] : resHigh[1];
        highHit   = bankSel ? 3'h4 : 3'h2;
      end
      temp_core_pkg::ADDR_R1_LOW: begin
        readValue = bankSel ? resLow[2] : resLow[1];
        lowHit    = bankSel ? 3'h4 : 3'h2;
      end
      temp_core_pkg::ADDR_R2_HIGH: begin
        readValue = resHigh[2];
        highHit   = 3'h4;
      end
      temp_core_pkg::ADDR_R2_LOW: begin
        readValue = resLow[2];
        lowHit    = 3'h4;
      end
      temp_core_pkg::ADDR_CFG1_RD: readValue = cfg1; // [RULE14]
      temp_core_pkg::ADDR_CFG2:    readValue = cfg2;
      default: readValue = temp_core_pkg::READ_DEFAULT;
    endcase
  end

  // result formatting at store time
  temp_format u_format (
    .tempQuarter (resultTemp),
    .extRange    (cfg1[temp_core_pkg::RANGE_BIT]), // [RULE5]
    .highByte    (fmtHigh),
    .lowByte     (fmtLow)
  );

  // standby drops converter results
  assign newResult = resultValid & ~standby; // [RULE16]

  // per-channel result storage and high-byte freeze
  for (genvar ch = 0; ch < 3; ch++) begin : g_chan
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        resHigh[ch]   <= temp_core_pkg::RESULT_RESET; // [RULE12]
        resLow[ch]    <= temp_core_pkg::RESULT_RESET;
        pendHigh[ch]  <= temp_core_pkg::RESULT_RESET;
        pendValid[ch] <= 1'b0;
      end else if (newResult && resultChannel == 2'(ch)) begin // [RULE11]
        resLow[ch] <= fmtLow; // [RULE2]
        if (frozen[ch] && !(rdLoad && highHit[ch])) begin // [RULE20]
          pendHigh[ch]  <= fmtHigh;
          pendValid[ch] <= 1'b1;
        end else begin
          resHigh[ch]   <= fmtHigh; // [RULE5]
          pendValid[ch] <= 1'b0;
        end
      end else if (rdLoad && highHit[ch] && pendValid[ch]) begin
        resHigh[ch]   <= pendHigh[ch]; // catch up after the read
        pendValid[ch] <= 1'b0;
      end
    end

    // low read arms, stop freezes, repeated start drops the arm
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        frozen[ch]    <= 1'b0;
        freezeArm[ch] <= 1'b0;
      end else if (rdLoad && highHit[ch]) begin
        frozen[ch]    <= 1'b0; // [RULE20]
        freezeArm[ch] <= 1'b0;
      end else if (rdLoad && lowHit[ch]) begin
        freezeArm[ch] <= 1'b1;
      end else if (stopCond) begin
        frozen[ch]    <= frozen[ch] | freezeArm[ch];
        freezeArm[ch] <= 1'b0;
      end else if (startCond) begin
        freezeArm[ch] <= 1'b0;
      end
    end
  end

  // shared pin function and alarm gating
  always_comb begin
    if (cfg1[temp_core_pkg::PIN_FUNC_BIT]) begin // [RULE17]
      pinAssert = secondOvertempReq;
    end else begin
      pinAssert = ~cfg1[temp_core_pkg::ALARM_MASK_BIT] & // [RULE15]
                  (localAlarmReq |
                   (remoteOneAlarmReq &
                    ~cfg1[temp_core_pkg::R1_BLOCK_BIT]) | // [RULE18]
                   (remoteTwoAlarmReq &
                    ~cfg1[temp_core_pkg::R2_BLOCK_BIT]));
    end
  end

  // registered pin drives and converter controls
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      alarmPinOe       <= 1'b0;
      overtempOe       <= 1'b0;
      conversionEnable <= 1'b0;
      extendedRange    <= 1'b0;
    end else begin
      alarmPinOe       <= pinAssert & ~standby; // [RULE16]
      overtempOe       <= overtempReq & ~standby;
      conversionEnable <= ~standby;
      extendedRange    <= cfg1[temp_core_pkg::RANGE_BIT]; // [RULE1]
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_result_ch0;
    newResult && resultChannel == temp_core_pkg::CH_LOCAL;
  endsequence

  sequence s_low_read_then_stop;
    freezeArm[1] ##0 stopCond;
  endsequence

  AST_PTR_RESET: assert property ($rose(rst_n) |-> regPtr == 8'h00) // [RULE10]
    else $error("pointer not zero after reset");
  AST_PTR_LOAD: assert property (ptrWrite |=> regPtr == $past(rxShift)) // [RULE8]
    else $error("pointer not loaded from first byte");
  AST_RO_IGNORE: assert property (regWrite && !newResult // [RULE22]
      |=> $stable(resHigh[0]) && $stable(resLow[1])) // [RULE11]
    else $error("result changed by a bus write");
  AST_BINARY_CLAMP: assert property ((s_result_ch0 and // [RULE3]
      (!cfg1[temp_core_pkg::RANGE_BIT] && resultTemp[11]))
      |=> resHigh[0] == 8'h00)
    else $error("negative result not clamped to zero");
  AST_OFFSET_ZERO: assert property ((s_result_ch0 and // [RULE4]
      (cfg1[temp_core_pkg::RANGE_BIT] && resultTemp == 12'h000))
      |=> resHigh[0] == 8'h40)
    else $error("zero degrees not offset by 64");
  AST_STANDBY_QUIET: assert property (standby ##1 standby // [RULE16]
      |-> !alarmPinOe && !overtempOe && !conversionEnable)
    else $error("outputs active in standby");
  AST_MASK_ALL: assert property (cfg1[7] && !cfg1[5] // [RULE15]
      ##1 cfg1[7] && !cfg1[5] |-> !alarmPinOe)
    else $error("masked alarm reached the pin");
  AST_LOCK_HOLD: assert property (locked && regWrite |=> $stable(cfg1) // [RULE19]
      && $stable(cfg2))
    else $error("locked register changed");
  AST_BANK_READ: assert property (rdLoad && bankSel // [RULE13]
      && regPtr == temp_core_pkg::ADDR_R1_HIGH |=> txShift == $past(resHigh[2]))
    else $error("bank select did not redirect read");
  AST_FREEZE_HOLD: assert property (s_low_read_then_stop // [RULE20]
      |=> frozen[1])
    else $error("high byte not frozen after low read");
  AST_FRAC_ZERO: assert property (resLow[1][5:0] == 6'h00 // [RULE21]
      && resLow[2][5:0] == 6'h00)
    else $error("low byte lower bits not zero");

endmodule : temp_sensor_register_core

// ===== pkg/temp_core_pkg.sv
// Purpose: shared constants and types of the thermometer register core
// Assumes: 8-bit registers, byte addresses as the host sends them
// Notes:   temperatures from the converter are signed quarter degrees
package temp_core_pkg;

  // register addresses
  localparam logic [7:0] ADDR_LOCAL    = 8'h00; // local result
  localparam logic [7:0] ADDR_R1_HIGH  = 8'h01; // remote one high byte
  localparam logic [7:0] ADDR_CFG1_RD  = 8'h03; // primary config, read
  localparam logic [7:0] ADDR_CFG1_WR  = 8'h09; // primary config, write
  localparam logic [7:0] ADDR_R1_LOW   = 8'h10; // remote one low byte
  localparam logic [7:0] ADDR_CFG2     = 8'h24; // secondary config
  localparam logic [7:0] ADDR_R2_HIGH  = 8'h30; // remote two high byte
  localparam logic [7:0] ADDR_R2_LOW   = 8'h33; // remote two low byte

  // reset values
  localparam logic [7:0] PTR_RESET     = 8'h00; // pointer after reset
  localparam logic [7:0] RESULT_RESET  = 8'h00; // all results
  localparam logic [7:0] CFG1_RESET    = 8'h00; // primary config
  localparam logic [7:0] CFG2_RESET    = 8'h00; // secondary config
  localparam logic [7:0] READ_DEFAULT  = 8'h00; // unmapped address reads

  // writable bits, reserved bits read zero
  localparam logic [7:0] CFG1_WMASK    = 8'hef; // bit 4 reserved
  localparam logic [7:0] CFG2_WMASK    = 8'h80; // bits 6..0 reserved

  // primary config fields
  localparam int ALARM_MASK_BIT        = 7; // suppress alarm pin
  localparam int STANDBY_BIT           = 6; // standby_select
  localparam int PIN_FUNC_BIT          = 5; // pin_function_select
  localparam int BANK_BIT              = 3; // remote two via remote one
  localparam int RANGE_BIT             = 2; // extended range
  localparam int R1_BLOCK_BIT          = 1; // remote_one_alarm_block
  localparam int R2_BLOCK_BIT          = 0; // remote_two_alarm_block
  // secondary config field
  localparam int LOCK_BIT              = 7; // settings lock

  // data format limits
  localparam logic signed [9:0]  DEFAULT_MIN_DEG = 10'sh000; // 0 degrees
  localparam logic signed [9:0]  DEFAULT_MAX_DEG = 10'sh07f; // 127 deg
  localparam logic signed [10:0] EXT_OFFSET      = 11'sh040; // +64
  localparam logic signed [10:0] EXT_MIN_CODE    = 11'sh000; // -64 deg
  localparam logic signed [10:0] EXT_MAX_CODE    = 11'sh0ff; // +191 deg
  localparam logic [5:0]         FRAC_PAD        = 6'h00;    // low bits

  // converter channel codes
  localparam logic [1:0] CH_LOCAL      = 2'h0;
  localparam logic [1:0] CH_REMOTE1    = 2'h1;
  localparam logic [1:0] CH_REMOTE2    = 2'h2;

  // serial bus byte engine
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_WDATA,
    BUS_WDATA_ACK,
    BUS_RDATA,
    BUS_MACK
  } bus_state_t;

endpackage : temp_core_pkg

// ===== logic/temp_format.sv
// Purpose: turn one converter result into high and low result bytes
// Assumes: input is signed quarter degrees, floor taken for whole degrees
// Notes:   purely combinational, applied when a result is stored
`timescale 1ns/1ns
module temp_format (
  input  wire logic signed [11:0] tempQuarter,
  input  wire logic               extRange,
  output logic             [7:0]  highByte,
  output logic             [7:0]  lowByte
);

  logic signed [9:0]  wholeDeg;  // floor of the temperature
  logic signed [10:0] offsetDeg; // temperature plus offset

  assign wholeDeg  = tempQuarter[11:2];
  assign offsetDeg = {wholeDeg[9], wholeDeg} + temp_core_pkg::EXT_OFFSET;

  // range clamp and encoding
  always_comb begin
    highByte = wholeDeg[7:0];
    lowByte  = {tempQuarter[1:0], temp_core_pkg::FRAC_PAD}; // [RULE21]
    if (extRange) begin
      // offset binary, clamped to the extended span
      if (offsetDeg < temp_core_pkg::EXT_MIN_CODE) begin // [RULE1]
        highByte = temp_core_pkg::EXT_MIN_CODE[7:0];
        lowByte  = 8'h00;
      end else if (offsetDeg > temp_core_pkg::EXT_MAX_CODE) begin
        highByte = temp_core_pkg::EXT_MAX_CODE[7:0];
        lowByte  = 8'h00;
      end else begin
        highByte = offsetDeg[7:0]; // [RULE4]
      end
    end else begin
      // plain binary, below zero reads 0, above 127 reads 127
      if (wholeDeg < temp_core_pkg::DEFAULT_MIN_DEG) begin // [RULE3]
        highByte = temp_core_pkg::DEFAULT_MIN_DEG[7:0];
        lowByte  = 8'h00;
      end else if (wholeDeg > temp_core_pkg::DEFAULT_MAX_DEG) begin
        highByte = temp_core_pkg::DEFAULT_MAX_DEG[7:0];
        lowByte  = 8'h00;
      end
    end
  end

endmodule : temp_format

// ===== bench/smbus_host_model.sv
// Purpose: serial bus host driving the clock and data pins
// Assumes: open-drain lines with pull-ups, 400 ns bit time
// Notes:   clock stands high between frames
`timescale 1ns/1ns
module smbus_host_model #(
  parameter logic [6:0] DEV = 7'h2a // arbitrary bus address
) (
  output logic      scl,    // bus clock
  output logic      hostOe, // host pulls data low
  input  wire logic sda     // resolved data line
);
  // bus idle, both lines released
  initial begin
    scl    = 1'b1;
    hostOe = 1'b0;
  end
  // one bit: low 300 ns, high 100 ns, sampled late in high
  task automatic bitx(input logic b, output logic s);
    scl = 1'b0;
    #25 hostOe = ~b;
    #275 scl = 1'b1;
    #90 s = sda;
    #10;
  endtask : bitx
  // stop: data rises while clock high
  task automatic stop;
    scl = 1'b0;
    #25 hostOe = 1'b1;
    #275 scl = 1'b1;
    #100 hostOe = 1'b0;
    #300;
  endtask : stop
  // eight bits msb first, then the ack slot
  task automatic xbyte(input logic [7:0] tx, input logic ak,
                       output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], s);
      rx[i] = s;
    end
    bitx(ak, s);
  endtask : xbyte
  // start, then register index first in every write
  task automatic wreg(input logic [7:0] p, input logic [7:0] d,
                      input logic wd);
    logic [7:0] r;
    hostOe = 1'b1;
    #200;
    xbyte({DEV, 1'b0}, 1'b1, r);
    xbyte(p, 1'b1, r);
    if (wd) xbyte(d, 1'b1, r);
    stop();
  endtask : wreg
  // one byte read at the current index, closed by a nack
  task automatic rcur(output logic [7:0] d);
    logic [7:0] r;
    hostOe = 1'b1;
    #200;
    xbyte({DEV, 1'b1}, 1'b1, r);
    xbyte(8'hff, 1'b1, d);
    stop();
  endtask : rcur
  // index write and stop, then a read at that index
  task automatic rreg(input logic [7:0] p, output logic [7:0] d);
    wreg(p, 8'h00, 1'b0);
    rcur(d);
  endtask : rreg
endmodule : smbus_host_model

// ===== bench/temp_sensor_register_core_tb_top.sv
// Purpose: self-checking bench of the thermometer register core
// Assumes: host model on the bus pins, converter strobes from here
// Notes:   random temperatures from a fixed-seed shift register
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  err_total++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module temp_sensor_register_core_tb_top;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary bus address
  // pin table: config, requests {ot,ot2,r2,r1,loc}, {alarm,ot}
  localparam logic [7:0] CFG_T [6] = '{8'h00, 8'h02, 8'h01, 8'h80,
                                       8'ha0, 8'h40};
  localparam logic [4:0] REQ_T [6] = '{5'h02, 5'h02, 5'h04, 5'h01,
                                       5'h18, 5'h1f};
  localparam logic [1:0] EXP_T [6] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0};
  logic        ref_clk, rst_n, scl, hostOe, sdaOe; // clock, reset, bus
  logic        resultValid;   // converter strobe
  logic [1:0]  resultChannel; // converter channel
  logic [11:0] resultTemp;    // quarter degrees
  logic [4:0]  req;           // limit requests
  logic        convEn, extRange, alarmOe, overOe; // observed outputs
  logic [31:0] seed;          // shift register state
  int          err_total, checks_done;
  wire         sda = ~(hostOe | sdaOe); // pulled-up data line
  temp_sensor_register_core #(.SLAVE_ADDR(DEV)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda),
    .sdaOut(), .sdaOe(sdaOe), .resultValid(resultValid),
    .resultChannel(resultChannel), .resultTemp(resultTemp),
    .localAlarmReq(req[0]), .remoteOneAlarmReq(req[1]),
    .remoteTwoAlarmReq(req[2]), .secondOvertempReq(req[3]),
    .overtempReq(req[4]), .conversionEnable(convEn),
    .extendedRange(extRange), .alarmPinOut(), .alarmPinOe(alarmOe),
    .overtempOut(), .overtempOe(overOe));
  smbus_host_model #(.DEV(DEV)) i_host (.scl(scl), .hostOe(hostOe),
                                        .sda(sda));
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // next shift register value
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // expected {high, low} bytes: clamp, offset, two fraction bits
  function automatic logic [15:0] expv(input logic [11:0] t,
                                       input logic x);
    int w;
    w = $signed(t) >>> 2;
    if (x) w = w + 64;
    if (w < 0) return 16'h0000;
    if (!x && w > 127) return 16'h7f00;
    if (x && w > 255) return 16'hff00;
    return {w[7:0], t[1:0], 6'h00};
  endfunction : expv
  // one converter result pulse
  task automatic result(input logic [1:0] ch, input logic [11:0] t);
    @(posedge ref_clk);
    resultValid   <= 1'b1;
    resultChannel <= ch;
    resultTemp    <= t;
    @(posedge ref_clk);
    resultValid   <= 1'b0;
  endtask : result
  // read one register and compare
  task automatic rchk(input logic [7:0] a, input logic [7:0] ex);
    logic [7:0] d;
    i_host.rreg(a, d);
    `CHK($sformatf("reg%h", a), ex, d)
  endtask : rchk
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // hang guard, about four times the expected run
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  // main sequence
  initial begin
    logic [11:0] t;
    logic [15:0] e;
    logic [7:0]  lastLoc, lastR2, rd;
    {rst_n, resultValid, resultChannel, resultTemp, req} = '0;
    seed = 32'd70754;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    result(2'h0, 12'h1ff); // local result before any index write
    e = expv(12'h1ff, 1'b0);
    i_host.rcur(rd);
    `CHK("ptr", e[15:8], rd)
    rchk(8'h30, 8'h00);
    rchk(8'h03, 8'h00);
    for (int r = 0; r < 2; r++) begin
      i_host.wreg(8'h09, {5'h0, r[0], 2'h0}, 1'b1);
      `CHK("range", r[0], extRange)
      for (int i = 0; i < 4; i++) begin
        seed = lfsr(seed);
        t = i == 0 ? (r ? 12'hf24 : 12'hffc) : i == 1 ? 12'h1ff : seed[11:0];
        result(2'(i % 3), t);
        e = expv(t, r[0]);
        if (i % 3 == 0) lastLoc = e[15:8];
        if (i % 3 == 2) lastR2 = e[15:8];
        if (i % 3 == 0) rchk(8'h00, e[15:8]);
        else begin
          rchk(i == 1 ? 8'h10 : 8'h33, e[7:0]);
          rchk(i == 1 ? 8'h01 : 8'h30, e[15:8]);
        end
      end
    end
    i_host.wreg(8'h00, 8'h55, 1'b1);
    rchk(8'h00, lastLoc);
    e = expv(12'h1ff, 1'b1); // remote one still holds its last result
    rchk(8'h10, e[7:0]);
    result(2'h1, 12'h000); // lands while the high byte is frozen
    result(2'h0, 12'h000);
    rchk(8'h01, e[15:8]);
    e = expv(12'h000, 1'b1);
    rchk(8'h01, e[15:8]);
    rchk(8'h00, e[15:8]);
    i_host.wreg(8'h09, 8'h0c, 1'b1);
    rchk(8'h01, lastR2);
    for (int k = 0; k < 6; k++) begin
      i_host.wreg(8'h09, CFG_T[k], 1'b1);
      @(posedge ref_clk);
      req <= REQ_T[k];
      repeat (3) @(posedge ref_clk);
      `CHK("pins", EXP_T[k], {alarmOe, overOe})
      req <= 5'h00;
    end
    `CHK("conv", 1'b0, convEn)
    i_host.wreg(8'h24, 8'h80, 1'b1);
    i_host.wreg(8'h09, 8'h00, 1'b1);
    rchk(8'h03, 8'h40);
    rchk(8'h24, 8'h80);
    rchk(8'h77, 8'h00);
    final_report();
  end
endmodule : temp_sensor_register_core_tb_top
